// ===== hw/pdrc_pkg.sv
// Shared constants and types of the MAC reset and start-of-packet
// interrupt control block.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus.
package pdrc_pkg;

  // Bus widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_SOP_EN = 14'h1a8a;
  localparam logic [IDX_W-1:0] IDX_RST_CTL = 14'h1a8b;
  localparam logic [IDX_W-1:0] IDX_SOP_FLAGS = 14'h1a8c;
  localparam logic [IDX_W-1:0] IDX_SOP_CLR = 14'h1a8d;
  localparam logic [IDX_W-1:0] IDX_TRANSMIT_CONTROL_FSM = 14'h1a8e;

  // Field layout.
  localparam int SOP_W = 5;
  localparam int TX_W = 4;
  localparam int RST_FULL_BIT = 7;
  localparam int RST_CODEC_BIT = 6;
  localparam int RST_PROTO_BIT = 0;
  localparam int TX_GO_BIT = 0;
  localparam int TX_HARD_BIT = 1;
  localparam int TX_CABLE_BIT = 2;
  localparam int TX_FWARN_BIT = 3;
  localparam int TX_HRD_EN_BIT = 4;

  // Reset values.
  localparam logic [SOP_W-1:0] SOP_RST = 5'h00;
  localparam logic [TX_W-1:0] TX_RST = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Signals driven by the bus master.
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } pdrc_axil_req_t;

  // Signals driven by this slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } pdrc_axil_rsp_t;

  // One committed register write.
  typedef struct packed {
    logic en;
    logic be;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } pdrc_wr_t;

  // State of the bus front end.
  typedef struct packed {
    logic aw_seen;
    logic w_seen;
    logic be;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } pdrc_port_t;

  // State of the control core.
  typedef struct packed {
    logic [SOP_W-1:0] en;
    logic [SOP_W-1:0] flags;
    logic full;
    logic codec;
    logic proto;
    logic [TX_W-1:0] tx;
    logic hrd_en;
    logic irq;
  } pdrc_core_t;

  // Word index of a byte address.
  function automatic logic [IDX_W-1:0] pdrc_idx(
    input logic [ADDR_W-1:0] addr
  );
    return addr[ADDR_W-1:2];
  endfunction : pdrc_idx

  // True for an index that maps to a register.
  function automatic logic pdrc_hit(input logic [IDX_W-1:0] idx);
    return (idx == IDX_SOP_EN) || (idx == IDX_RST_CTL) ||
      (idx == IDX_SOP_FLAGS) || (idx == IDX_SOP_CLR) ||
      (idx == IDX_TRANSMIT_CONTROL_FSM);
  endfunction : pdrc_hit

endpackage : pdrc_pkg

// ===== hw/pdrc_axil_port.sv
// AXI4-Lite slave front end of the reset and interrupt control block.
// Assumes a master on the same clock; the core answers reads at once.
`timescale 1ns/1ps
module pdrc_axil_port
  import pdrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire pdrc_axil_req_t bus_req,
  output pdrc_axil_rsp_t bus_rsp,
  output pdrc_wr_t wr,
  output logic [IDX_W-1:0] rd_idx,
  input wire logic [7:0] rd_data
);

  pdrc_port_t s_q;
  pdrc_port_t s_d;

  // Ready and answer signals follow the registered state only.
  always_comb
  begin
    bus_rsp.awready = !s_q.aw_seen && !s_q.bvalid;
    bus_rsp.wready = !s_q.w_seen && !s_q.bvalid;
    bus_rsp.bvalid = s_q.bvalid;
    bus_rsp.bresp = s_q.bresp;
    bus_rsp.arready = !s_q.rvalid;
    bus_rsp.rvalid = s_q.rvalid;
    bus_rsp.rdata = s_q.rdata;
    bus_rsp.rresp = s_q.rresp;
    rd_idx = pdrc_idx(bus_req.araddr);
  end

  // Address and data are taken in any order; the write commits once
  // both are held, and the response is raised in the same edge.
  always_comb
  begin
    s_d = s_q;
    wr = '0;
    if (s_q.bvalid && bus_req.bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (bus_rsp.awready && bus_req.awvalid)
    begin
      s_d.aw_seen = 1'b1;
      s_d.idx = pdrc_idx(bus_req.awaddr);
    end
    if (bus_rsp.wready && bus_req.wvalid)
    begin
      s_d.w_seen = 1'b1;
      s_d.data = bus_req.wdata[7:0];
      s_d.be = bus_req.wstrb[0];
    end
    if (s_q.aw_seen && s_q.w_seen)
    begin
      wr.en = pdrc_hit(s_q.idx);
      wr.be = s_q.be;
      wr.idx = s_q.idx;
      wr.data = s_q.data;
      s_d.aw_seen = 1'b0;
      s_d.w_seen = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = pdrc_hit(s_q.idx) ? RESP_OKAY : RESP_SLVERR;
    end
    // A read is answered in the same edge that takes it.
    if (s_q.rvalid && bus_req.rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (bus_rsp.arready && bus_req.arvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h00_0000, rd_data};
      s_d.rresp = pdrc_hit(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : pdrc_axil_port

// ===== hw/pdrc_reset_sop_ctrl.sv
// Top of the MAC reset control and start-of-packet interrupt block.
// Assumes start-of-packet event pulses from receive logic on the same
// clock, and that the MAC logic around it obeys the reset levels.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps

module pdrc_reset_sop_ctrl
  import pdrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire pdrc_axil_req_t bus_req,
  output pdrc_axil_rsp_t bus_rsp,
  input wire logic [SOP_W-1:0] sop_event,
  output logic irq,
  output logic mac_soft_rst,
  output logic codec_soft_rst,
  output logic protocol_soft_rst,
  output logic tx_launch,
  output logic tx_hard_rst_req,
  output logic tx_cable_rst_req,
  output logic fast_warning_transmit_enable,
  output logic hard_rst_detect_en
);

  pdrc_core_t s_q;
  pdrc_core_t s_d;
  pdrc_wr_t wr;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic [SOP_W-1:0] clr;

  // Bus slave front end.
  pdrc_axil_port u_port (
    .clock(clock),
    .rst_b(rst_b),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .wr(wr),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  // Read view; reserved bits and the clear register read as zero.
  always_comb
  begin
    rd_data = BYTE_ZERO;
    unique case (rd_idx)
      IDX_SOP_EN: rd_data[SOP_W-1:0] = s_q.en;
      IDX_RST_CTL:
      begin
        rd_data[RST_FULL_BIT] = s_q.full;
        rd_data[RST_CODEC_BIT] = s_q.codec;
        rd_data[RST_PROTO_BIT] = s_q.proto;
      end
      IDX_SOP_FLAGS: rd_data[SOP_W-1:0] = s_q.flags;
      IDX_TRANSMIT_CONTROL_FSM:
      begin
        rd_data[TX_W-1:0] = s_q.tx;
        rd_data[TX_HRD_EN_BIT] = s_q.hrd_en;
      end
      default: rd_data = BYTE_ZERO;
    endcase
  end

  // Next state: register writes, sticky flags and the reset holds.
  always_comb
  begin
    s_d = s_q;
    clr = SOP_RST;
    if (wr.en && wr.be)
    begin
      unique case (wr.idx)
        IDX_SOP_EN: s_d.en = wr.data[SOP_W-1:0];
        IDX_RST_CTL:
        begin
          s_d.full = wr.data[RST_FULL_BIT];
          s_d.codec = wr.data[RST_CODEC_BIT];
          s_d.proto = wr.data[RST_PROTO_BIT];
        end
        IDX_SOP_CLR: clr = wr.data[SOP_W-1:0];
        IDX_TRANSMIT_CONTROL_FSM:
        begin
          s_d.tx = wr.data[TX_W-1:0];
          s_d.hrd_en = wr.data[TX_HRD_EN_BIT];
        end
        default: s_d = s_q;
      endcase
    end
    // An event in the clearing cycle wins; enables do not gate it.
    s_d.flags = (s_q.flags & ~clr) | sop_event;
    // Transmit requests stay cleared while the protocol reset is
    // held; the detection enable is left alone.
    if (s_q.proto)
    begin
      s_d.tx = TX_RST;
    end
    // Full reset holds everything but its own bit at power-on values.
    if (s_q.full)
    begin
      s_d.en = SOP_RST;
      s_d.flags = SOP_RST;
      s_d.codec = 1'b0;
      s_d.proto = 1'b0;
      s_d.tx = TX_RST;
      s_d.hrd_en = 1'b0;
    end
    s_d.irq = |(s_d.flags & s_d.en);
  end

  // State register; the pin or a reset register write clears the full reset bit.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Reset levels to the rest of the MAC. The codec reset stays apart
  // from the protocol reset, so the codec keeps running through it.
  assign mac_soft_rst = s_q.full;
  assign codec_soft_rst = s_q.codec | s_q.full;
  assign protocol_soft_rst = s_q.proto | s_q.full;

  // Transmit request bits and receiver detection enable.
  assign tx_launch = s_q.tx[TX_GO_BIT];
  assign tx_hard_rst_req = s_q.tx[TX_HARD_BIT];
  assign tx_cable_rst_req = s_q.tx[TX_CABLE_BIT];
  assign fast_warning_transmit_enable = s_q.tx[TX_FWARN_BIT];
  assign hard_rst_detect_en = s_q.hrd_en;
  assign irq = s_q.irq;

  // Helper terms for the checks below.
  logic wr_en_reg;
  logic wr_rst_reg;
  logic wr_tx_reg;
  assign wr_en_reg = wr.en && wr.be && (wr.idx == IDX_SOP_EN);
  assign wr_rst_reg = wr.en && wr.be && (wr.idx == IDX_RST_CTL);
  assign wr_tx_reg = wr.en && wr.be && (wr.idx == IDX_TRANSMIT_CONTROL_FSM);
  logic wr_clr_reg;
  assign wr_clr_reg = wr.en && wr.be && (wr.idx == IDX_SOP_CLR);

  // Enable writes land in five bits when not held in reset.
  property p_en_write;
    @(posedge clock) disable iff (!rst_b)
    wr_en_reg && !s_q.full |=> s_q.en == $past(wr.data[SOP_W-1:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("Enable write not stored.");

  // An event sets its flag whatever the enable says.
  property p_flag_set;
    @(posedge clock) disable iff (!rst_b)
    (sop_event != SOP_RST) && !s_q.full
      |=> (s_q.flags & $past(sop_event)) == $past(sop_event);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Event flag not set.");

  // No interrupt without an enabled pending flag, one edge later.
  property p_irq_gate;
    @(posedge clock) disable iff (!rst_b)
    ((s_q.flags & s_q.en) == SOP_RST) ##1 ((s_q.flags & s_q.en)
      == SOP_RST) |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Interrupt raised while masked.");

  // Enables and interrupt are clear right after reset release.
  property p_por_clear;
    @(posedge clock) disable iff (!rst_b)
    $rose(rst_b) |-> (s_q.en == SOP_RST) && !irq;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("Enables not clear after reset.");

  // Full reset wipes enables and flags one edge on.
  property p_full_wipe;
    @(posedge clock) disable iff (!rst_b)
    s_q.full ##1 s_q.full |-> (s_q.en == SOP_RST) &&
      (s_q.flags == SOP_RST) && mac_soft_rst && protocol_soft_rst;
  endproperty
  a_full_wipe: assert property (p_full_wipe)
    else $error("Full reset did not clear state.");

  // The full reset bit falls only on a reset register write.
  property p_full_keep;
    @(posedge clock) disable iff (!rst_b)
    s_q.full && !wr_rst_reg |=> s_q.full;
  endproperty
  a_full_keep: assert property (p_full_keep)
    else $error("Full reset bit cleared itself.");

  // Codec reset follows its bit and leaves protocol logic running.
  property p_codec;
    @(posedge clock) disable iff (!rst_b)
    s_q.codec && !s_q.proto && !s_q.full
      |-> codec_soft_rst && !protocol_soft_rst;
  endproperty
  a_codec: assert property (p_codec)
    else $error("Codec reset level wrong.");

  // Detection enable survives a held protocol reset.
  property p_detect_keep;
    @(posedge clock) disable iff (!rst_b)
    s_q.proto && !s_q.full && !wr_tx_reg |=> $stable(s_q.hrd_en);
  endproperty
  a_detect_keep: assert property (p_detect_keep)
    else $error("Detection enable lost.");

  // Transmit requests are clear one edge into a protocol reset.
  property p_tx_clear;
    @(posedge clock) disable iff (!rst_b)
    s_q.proto |=> (s_q.tx == TX_RST) && !tx_launch;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("Transmit bits not cleared.");

  // Protocol reset leaves enables and flags alone.
  property p_proto_spare;
    @(posedge clock) disable iff (!rst_b)
    s_q.proto && !s_q.full && !wr.en && (sop_event == SOP_RST)
      |=> $stable(s_q.en) && $stable(s_q.flags);
  endproperty
  a_proto_spare: assert property (p_proto_spare)
    else $error("Protocol reset touched registers.");

  // Protocol reset alone never resets the codec.
  property p_codec_spare;
    @(posedge clock) disable iff (!rst_b)
    s_q.proto && !s_q.codec && !s_q.full |-> !codec_soft_rst;
  endproperty
  a_codec_spare: assert property (p_codec_spare)
    else $error("Protocol reset reached the codec.");

  // The protocol reset level drops as soon as its bit is cleared.
  property p_proto_release;
    @(posedge clock) disable iff (!rst_b)
    $fell(s_q.proto) && !s_q.full |-> !protocol_soft_rst;
  endproperty
  a_proto_release: assert property (p_proto_release)
    else $error("Protocol reset held too long.");

  // Reserved enable bits always read back as zero.
  property p_en_reserved;
    @(posedge clock) disable iff (!rst_b)
    rd_idx == IDX_SOP_EN |-> rd_data[7:SOP_W] == 3'b000;
  endproperty
  a_en_reserved: assert property (p_en_reserved)
    else $error("Reserved enable bits not zero.");

  // A pending flag whose enable is set drives the interrupt.
  property p_irq_raise;
    @(posedge clock) disable iff (!rst_b)
    (s_q.flags & s_q.en) != SOP_RST |-> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("Enabled flag gave no interrupt.");

  // Flags are sticky unless cleared or wiped by the full reset.
  property p_flag_sticky;
    @(posedge clock) disable iff (!rst_b)
    !s_q.full && !wr_clr_reg |=> (s_q.flags & $past(s_q.flags))
      == $past(s_q.flags);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Event flag lost without a clear.");

  // The full reset drives every reset level of the MAC.
  property p_full_levels;
    @(posedge clock) disable iff (!rst_b)
    s_q.full |-> mac_soft_rst && codec_soft_rst && protocol_soft_rst;
  endproperty
  a_full_levels: assert property (p_full_levels)
    else $error("Full reset levels missing.");

  // Full reset clears the transmit bits and detection one edge on.
  property p_detect_wipe;
    @(posedge clock) disable iff (!rst_b)
    s_q.full |=> !hard_rst_detect_en && (s_q.tx == TX_RST);
  endproperty
  a_detect_wipe: assert property (p_detect_wipe)
    else $error("Full reset left transmit state.");

  // The codec reset level drops as soon as its bit is cleared.
  property p_codec_release;
    @(posedge clock) disable iff (!rst_b)
    $fell(s_q.codec) && !s_q.full |-> !codec_soft_rst;
  endproperty
  a_codec_release: assert property (p_codec_release)
    else $error("Codec reset held too long.");

  // The MAC reset level drops as soon as the full bit is cleared.
  property p_full_release;
    @(posedge clock) disable iff (!rst_b)
    $fell(s_q.full) |-> !mac_soft_rst;
  endproperty
  a_full_release: assert property (p_full_release)
    else $error("MAC reset held too long.");

  // Main scenarios.
  property p_cov_irq;
    @(posedge clock) disable iff (!rst_b)
    $rose(irq);
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_full;
    @(posedge clock) disable iff (!rst_b)
    $fell(s_q.full);
  endproperty
  c_cov_full: cover property (p_cov_full);

  property p_cov_proto;
    @(posedge clock) disable iff (!rst_b)
    s_q.proto && s_q.hrd_en;
  endproperty
  c_cov_proto: cover property (p_cov_proto);

  property p_cov_race;
    @(posedge clock) disable iff (!rst_b)
    ((clr & sop_event) != SOP_RST);
  endproperty
  c_cov_race: cover property (p_cov_race);

  property p_cov_codec;
    @(posedge clock) disable iff (!rst_b)
    s_q.codec && !s_q.full;
  endproperty
  c_cov_codec: cover property (p_cov_codec);

endmodule : pdrc_reset_sop_ctrl

// ===== verification/test_pdrc_reset_sop_ctrl.sv
// Self-checking bench of the MAC reset and start-of-packet interrupt block.
// Assumes the design package is compiled first; the bench drives all ports.
`timescale 1ns/1ps
module test_pdrc_reset_sop_ctrl
  import pdrc_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  pdrc_axil_req_t req = '0;
  pdrc_axil_rsp_t rsp;
  logic [SOP_W-1:0] sop = '0;
  logic irq;
  wire logic [7:0] outs;
  logic [1:0] resp;
  logic [7:0] data;
  logic [7:0] d;
  logic [7:0] m;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h9021;

  // Clock of 50 ns period.
  always #25 clock = ~clock;

  // Reset levels and transmit bits are gathered into one byte.
  pdrc_reset_sop_ctrl pdrc_reset_sop_ctrl_i (
    .clock(clock), .rst_b(rst_b), .bus_req(req), .bus_rsp(rsp),
    .sop_event(sop), .irq(irq), .mac_soft_rst(outs[7]),
    .codec_soft_rst(outs[6]), .protocol_soft_rst(outs[5]),
    .tx_launch(outs[4]), .tx_hard_rst_req(outs[3]),
    .tx_cable_rst_req(outs[2]), .fast_warning_transmit_enable(outs[1]),
    .hard_rst_detect_en(outs[0])
  );

  // Expected read value of the enable register after a write.
  function automatic logic [7:0] en_exp(input logic [7:0] v);
    return {3'b000, v[4:0]};
  endfunction : en_exp

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Waits some edges, then stops at a falling edge where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // One bus write; ready is sampled at the falling edge before the take.
  task automatic wr(input logic [IDX_W-1:0] ix, input logic [7:0] v);
    logic ta;
    logic tw;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= {ix, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, v};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever
    begin
      @(negedge clock);
      if (!req.awvalid && !req.wvalid)
        break;
      ta = rsp.awready;
      tw = rsp.wready;
      @(posedge clock);
      if (ta)
        req.awvalid <= 1'b0;
      if (tw)
        req.wvalid <= 1'b0;
    end
    forever
    begin
      if (rsp.bvalid)
        break;
      @(negedge clock);
    end
    resp = rsp.bresp;
    @(posedge clock);
    req.bready <= 1'b0;
  endtask : wr

  // One bus read; the answer lands in data and resp.
  task automatic rd(input logic [IDX_W-1:0] ix);
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= {ix, 2'b00};
    req.rready <= 1'b1;
    forever
    begin
      @(negedge clock);
      if (rsp.arready)
        break;
    end
    @(posedge clock);
    req.arvalid <= 1'b0;
    forever
    begin
      @(negedge clock);
      if (rsp.rvalid)
        break;
    end
    data = rsp.rdata[7:0];
    resp = rsp.rresp;
    @(posedge clock);
    req.rready <= 1'b0;
  endtask : rd

  // Raises start-of-packet events for one cycle.
  task automatic pulse(input logic [SOP_W-1:0] b);
    @(posedge clock);
    sop <= b;
    @(posedge clock);
    sop <= '0;
  endtask : pulse

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence of scenarios.
  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rd(IDX_SOP_EN);
    chk("sop_en", data, 8'h00);
    rd(IDX_RST_CTL);
    chk("rst_ctl", data, 8'h00);
    settle(0);
    chk("outs", outs, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    $display("Test reset values done");
    wr(IDX_SOP_EN, 8'hff);
    chk("wr_resp", {6'h00, resp}, {6'h00, RESP_OKAY});
    rd(IDX_SOP_EN);
    chk("sop_en", data, 8'h1f);
    repeat (8)
    begin
      d = 8'($random(seed));
      wr(IDX_SOP_EN, d);
      rd(IDX_SOP_EN);
      chk("sop_en", data, en_exp(d));
    end
    wr(14'h1a90, 8'h5a);
    chk("wr_resp", {6'h00, resp}, {6'h00, RESP_SLVERR});
    rd(14'h1a90);
    chk("rd_resp", {6'h00, resp}, {6'h00, RESP_SLVERR});
    chk("rd_unmapped", data, 8'h00);
    $display("Test enable field done");
    for (int i = 0; i < SOP_W; i++)
    begin
      m = 8'(1 << i);
      d = 8'($random(seed)) & 8'h1f & ~m;
      wr(IDX_SOP_EN, d);
      pulse(m[4:0]);
      rd(IDX_SOP_FLAGS);
      chk("flags", data, m);
      settle(0);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(IDX_SOP_EN, d | m);
      settle(1);
      chk("irq", {7'h00, irq}, 8'h01);
      wr(IDX_SOP_CLR, m);
      settle(1);
      chk("irq", {7'h00, irq}, 8'h00);
      rd(IDX_SOP_FLAGS);
      chk("flags", data, 8'h00);
    end
    // An event in the same edge as its clear keeps the flag set.
    pulse(5'h05);
    fork
      wr(IDX_SOP_CLR, 8'h1f);
      begin
        @(posedge clock);
        pulse(5'h04);
      end
    join
    rd(IDX_SOP_FLAGS);
    chk("flags_race", data, 8'h04);
    wr(IDX_SOP_CLR, 8'h04);
    rd(IDX_SOP_FLAGS);
    chk("flags", data, 8'h00);
    $display("Test event flags done");
    wr(IDX_SOP_EN, 8'h15);
    wr(IDX_TRANSMIT_CONTROL_FSM, 8'h1f);
    settle(0);
    chk("outs", outs, 8'h1f);
    wr(IDX_RST_CTL, 8'h01);
    settle(1);
    chk("outs", outs, 8'h21);
    wr(IDX_TRANSMIT_CONTROL_FSM, 8'h1f);
    settle(1);
    chk("outs", outs, 8'h21);
    rd(IDX_SOP_EN);
    chk("sop_en", data, 8'h15);
    rd(IDX_RST_CTL);
    chk("rst_ctl", data, 8'h01);
    wr(IDX_RST_CTL, 8'h00);
    settle(0);
    chk("outs", outs, 8'h01);
    wr(IDX_TRANSMIT_CONTROL_FSM, 8'h0f);
    settle(0);
    chk("outs", outs, 8'h1e);
    $display("Test protocol reset done");
    wr(IDX_RST_CTL, 8'h40);
    settle(0);
    chk("outs", outs, 8'h5e);
    rd(IDX_SOP_EN);
    chk("sop_en", data, 8'h15);
    wr(IDX_RST_CTL, 8'h00);
    $display("Test codec reset done");
    pulse(5'h01);
    settle(1);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(IDX_RST_CTL, 8'h80);
    settle(1);
    chk("outs", outs, 8'he0);
    chk("irq", {7'h00, irq}, 8'h00);
    pulse(5'h1f);
    wr(IDX_SOP_EN, 8'h1f);
    rd(IDX_SOP_EN);
    chk("sop_en", data, 8'h00);
    rd(IDX_SOP_FLAGS);
    chk("flags", data, 8'h00);
    rd(IDX_RST_CTL);
    chk("rst_ctl", data, 8'h80);
    wr(IDX_RST_CTL, 8'h00);
    settle(0);
    chk("outs", outs, 8'h00);
    wr(IDX_SOP_EN, 8'h15);
    wr(IDX_TRANSMIT_CONTROL_FSM, 8'h10);
    rd(IDX_SOP_EN);
    chk("sop_en", data, 8'h15);
    settle(0);
    chk("outs", outs, 8'h01);
    wr(IDX_RST_CTL, 8'h80);
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    rd(IDX_RST_CTL);
    chk("rst_ctl", data, 8'h00);
    settle(0);
    chk("outs", outs, 8'h00);
    $display("Test full reset done");
    tally_and_finish();
  end

endmodule : test_pdrc_reset_sop_ctrl
